// >>> src/cpu_register_file_flags.v
// core register file with alternate set, special registers and flag logic
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "regfile_consts.vh"
module cpu_register_file_flags (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clk_en,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // core datapath side
  input  wire        opcode_fetch_cycle,
  input  wire        exchange_sets,
  input  wire [2:0]  flag_op,
  input  wire [15:0] op_a,
  input  wire [15:0] op_b,
  input  wire        shift_carry,
  input  wire        index_sel,
  input  wire [7:0]  displacement,
  input  wire        disp_subtract,
  output reg  [15:0] index_address,
  output reg  [15:0] vector_address,
  input  wire [7:0]  vector_low,
  output reg  [15:0] result
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [7:0]  acc;
  reg  [7:0]  status_flags;
  reg  [15:0] pair_first;
  reg  [15:0] pair_second;
  reg  [15:0] pair_third;
  reg  [7:0]  shadow_acc;
  reg  [7:0]  shadow_flags;
  reg  [15:0] shadow_first;
  reg  [15:0] shadow_second;
  reg  [15:0] shadow_third;
  reg  [7:0]  vector_base;
  reg  [7:0]  refresh;
  reg  [15:0] index_first;
  reg  [15:0] index_second;
  reg  [15:0] stack_top;
  reg  [15:0] fetch_pointer;
  reg         dp_write;
  reg  [7:0]  dp_addr;
  reg         dp_byte;
  reg  [7:0]  next_flags;
  reg  [16:0] sum;
  reg  [15:0] res;
  reg  [15:0] base;
  reg  [31:0] rd_mux;
  reg  [31:0] rd_new;
  wire        bus_go;
  wire        dp_pair;
  wire        dp_store;
  wire [1:0]  dp_lane;
  wire [7:0]  a_lo;
  wire [7:0]  b_lo;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function even_parity;
    input [7:0] v;
    begin
      even_parity = ~^v;
    end
  endfunction
  // a byte store changes only its own half of a pair; a wider store must start on the pair
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input        byte_wr;
    input [1:0]  lane;
    begin
      if (byte_wr && lane == 2'h0) begin                             // see RULE_01
        merge16 = {old[15:8], d[7:0]};
      end else if (byte_wr && lane == 2'h1) begin
        merge16 = {d[15:8], old[7:0]};
      end else if (!byte_wr && lane == 2'h0) begin
        merge16 = d[15:0];
      end else begin
        merge16 = old;
      end
    end
  endfunction
  function [7:0] word_of;
    input [7:0] a;
    begin
      word_of = {a[7:2], 2'b00};
    end
  endfunction
  // carry into a bit is the xor of both operand bits and the result bit;
  // the same holds for the borrow, so add and subtract share it
  function half_carry;
    input a_bit;
    input b_bit;
    input s_bit;
    begin
      half_carry = a_bit ^ b_bit ^ s_bit;
    end
  endfunction
  assign a_lo      = op_a[7:0];
  assign b_lo      = op_b[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_go    = hsel & hready & htrans[1];
  assign dp_lane   = dp_addr[1:0];
  assign dp_pair   = (word_of(dp_addr) == `ADDR_PAIR1) | (word_of(dp_addr) == `ADDR_PAIR2) |
                     (word_of(dp_addr) == `ADDR_PAIR3);
  // 8-bit and whole 16-bit registers only take stores that start on their own word
  assign dp_store  = dp_write & (dp_pair | (dp_lane == 2'h0));
  // ------------------------------------------------------------
  // flag computation
  // ------------------------------------------------------------
  always @* begin
    next_flags = status_flags;
    sum = 17'h00000;
    res = 16'h0000;
    case (flag_op)
      `FOP_ADD8, `FOP_SUB8: begin
        if (flag_op == `FOP_SUB8) begin
          sum = {9'h000, a_lo} - {9'h000, b_lo};
        end else begin
          sum = {9'h000, a_lo} + {9'h000, b_lo};
        end
        res = {8'h00, sum[7:0]};
        next_flags[`FLAG_SIGN]  = sum[7];                        // see RULE_11
        next_flags[`FLAG_ZERO]  = (sum[7:0] == 8'h00);           // see RULE_12
        next_flags[`FLAG_HALF]  = half_carry(a_lo[4], b_lo[4], sum[4]); // see RULE_13
        next_flags[`FLAG_PV]    = (flag_op == `FOP_SUB8) ?       // see RULE_15
          ((a_lo[7] ^ b_lo[7]) & (a_lo[7] ^ sum[7])) :
          (~(a_lo[7] ^ b_lo[7]) & (a_lo[7] ^ sum[7]));
        next_flags[`FLAG_NEG]   = (flag_op == `FOP_SUB8);        // see RULE_16
        next_flags[`FLAG_CARRY] = sum[8];                        // see RULE_17
      end
      `FOP_ADD16, `FOP_SUB16: begin
        if (flag_op == `FOP_SUB16) begin
          sum = {1'b0, op_a} - {1'b0, op_b};
        end else begin
          sum = {1'b0, op_a} + {1'b0, op_b};
        end
        res = sum[15:0];
        next_flags[`FLAG_SIGN]  = sum[15];                       // see RULE_11
        next_flags[`FLAG_ZERO]  = (sum[15:0] == 16'h0000);       // see RULE_12
        // word operations take the carry out of bit 11, which needs the full low sum
        next_flags[`FLAG_HALF]  = half_carry(op_a[12], op_b[12], sum[12]); // see RULE_13
        next_flags[`FLAG_PV]    = (flag_op == `FOP_SUB16) ?      // see RULE_15
          ((op_a[15] ^ op_b[15]) & (op_a[15] ^ sum[15])) :
          (~(op_a[15] ^ op_b[15]) & (op_a[15] ^ sum[15]));
        next_flags[`FLAG_NEG]   = (flag_op == `FOP_SUB16);       // see RULE_16
        next_flags[`FLAG_CARRY] = sum[16];                       // see RULE_17
      end
      `FOP_LOGIC: begin
        // operand b already holds the logic result from the datapath
        res = {8'h00, b_lo};
        next_flags[`FLAG_SIGN]  = b_lo[7];                       // see RULE_11
        next_flags[`FLAG_ZERO]  = (b_lo == 8'h00);               // see RULE_12
        next_flags[`FLAG_PV]    = even_parity(b_lo);             // see RULE_14
        next_flags[`FLAG_NEG]   = 1'b0;
        next_flags[`FLAG_CARRY] = 1'b0;
      end
      `FOP_SHIFT: begin
        next_flags[`FLAG_CARRY] = shift_carry;                   // see RULE_17
        next_flags[`FLAG_HALF]  = 1'b0;
        next_flags[`FLAG_NEG]   = 1'b0;
      end
      default: begin
        next_flags = status_flags;
      end
    endcase
  end
  // ------------------------------------------------------------
  // address and result outputs
  // ------------------------------------------------------------
  always @* begin
    base = index_sel ? index_second : index_first;
  end
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      index_address  <= `RST_WORD;
      vector_address <= `RST_WORD;
      result         <= `RST_WORD;
    end else if (clk_en) begin
      index_address  <= disp_subtract ? base - {8'h00, displacement}   // see RULE_08
                                      : base + {8'h00, displacement};
      vector_address <= {vector_base, vector_low};                     // see RULE_04
      result         <= res;
    end
  end
  // ------------------------------------------------------------
  // register state and bus writes
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dp_write      <= 1'b0;
      dp_addr       <= 8'h00;
      dp_byte       <= 1'b0;
      acc           <= `RST_BYTE;
      status_flags  <= `RST_BYTE;                                     // see RULE_18
      pair_first    <= `RST_WORD;
      pair_second   <= `RST_WORD;
      pair_third    <= `RST_WORD;
      shadow_acc    <= `RST_BYTE;
      shadow_flags  <= `RST_BYTE;
      shadow_first  <= `RST_WORD;
      shadow_second <= `RST_WORD;
      shadow_third  <= `RST_WORD;
      vector_base   <= `RST_BYTE;                                     // see RULE_05
      refresh       <= `RST_BYTE;                                     // see RULE_07
      index_first   <= `RST_WORD;
      index_second  <= `RST_WORD;
      stack_top     <= `RST_WORD;                                     // see RULE_09
      fetch_pointer <= `RST_WORD;                                     // see RULE_10
    end else if (clk_en) begin
      dp_write <= bus_go & hwrite;
      dp_addr  <= haddr[7:0];
      dp_byte  <= (hsize == 3'h0);
      if (opcode_fetch_cycle) begin
        refresh[6:0]  <= refresh[6:0] + 7'h01;                        // see RULE_06
        fetch_pointer <= fetch_pointer + 16'h0001;                    // see RULE_10
      end
      status_flags <= next_flags;
      if (exchange_sets) begin
        // one-cycle swap of every main and alternate register
        acc           <= shadow_acc;                                  // see RULE_19
        shadow_acc    <= acc;                                         // see RULE_02
        status_flags  <= shadow_flags;
        shadow_flags  <= status_flags;
        pair_first    <= shadow_first;
        shadow_first  <= pair_first;
        pair_second   <= shadow_second;
        shadow_second <= pair_second;
        pair_third    <= shadow_third;
        shadow_third  <= pair_third;
      end
      // bus write wins over datapath updates in the same cycle
      if (dp_store) begin
        case (word_of(dp_addr))
          `ADDR_ACC:     acc           <= hwdata[7:0];
          `ADDR_FLAGS:   status_flags  <= hwdata[7:0];                // see RULE_18
          `ADDR_PAIR1:   pair_first    <= merge16(pair_first, hwdata, dp_byte, dp_lane);
          `ADDR_PAIR2:   pair_second   <= merge16(pair_second, hwdata, dp_byte, dp_lane);
          `ADDR_PAIR3:   pair_third    <= merge16(pair_third, hwdata, dp_byte, dp_lane);
          `ADDR_INDEX1:  index_first   <= hwdata[15:0];               // see RULE_03
          `ADDR_INDEX2:  index_second  <= hwdata[15:0];
          `ADDR_STACK:   stack_top     <= hwdata[15:0];
          `ADDR_FETCH:   fetch_pointer <= hwdata[15:0];
          `ADDR_VECBASE: vector_base   <= hwdata[7:0];
          `ADDR_REFRESH: refresh       <= hwdata[7:0];
          default:       acc           <= acc;
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // read data, registered in the address phase
  // ------------------------------------------------------------
  always @* begin
    rd_mux = 32'h00000000;
    case (word_of(haddr[7:0]))
      `ADDR_ACC:     rd_mux = {24'h000000, acc};
      `ADDR_FLAGS:   rd_mux = {24'h000000, status_flags};
      `ADDR_PAIR1:   rd_mux = {16'h0000, pair_first};
      `ADDR_PAIR2:   rd_mux = {16'h0000, pair_second};
      `ADDR_PAIR3:   rd_mux = {16'h0000, pair_third};
      `ADDR_INDEX1:  rd_mux = {16'h0000, index_first};
      `ADDR_INDEX2:  rd_mux = {16'h0000, index_second};
      `ADDR_STACK:   rd_mux = {16'h0000, stack_top};
      `ADDR_FETCH:   rd_mux = {16'h0000, fetch_pointer};
      `ADDR_VECBASE: rd_mux = {24'h000000, vector_base};
      `ADDR_REFRESH: rd_mux = {24'h000000, refresh};
      `ADDR_SHADOW:  rd_mux = {16'h0000, shadow_acc, shadow_flags};
      default:       rd_mux = 32'h00000000;
    endcase
  end
  // a read taken at the edge that stores the previous write must see the new
  // value, so a back-to-back write then read of one register stays coherent
  always @* begin
    rd_new = rd_mux;
    if (dp_store && word_of(dp_addr) == word_of(haddr[7:0])) begin
      case (word_of(dp_addr))
        `ADDR_ACC, `ADDR_FLAGS, `ADDR_VECBASE, `ADDR_REFRESH: begin
          rd_new = {24'h000000, hwdata[7:0]};
        end
        `ADDR_PAIR1:   rd_new = {16'h0000, merge16(pair_first, hwdata, dp_byte, dp_lane)};
        `ADDR_PAIR2:   rd_new = {16'h0000, merge16(pair_second, hwdata, dp_byte, dp_lane)};
        `ADDR_PAIR3:   rd_new = {16'h0000, merge16(pair_third, hwdata, dp_byte, dp_lane)};
        `ADDR_INDEX1, `ADDR_INDEX2, `ADDR_STACK, `ADDR_FETCH: begin
          rd_new = {16'h0000, hwdata[15:0]};
        end
        default:       rd_new = rd_mux;
      endcase
    end
  end
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (clk_en && bus_go && !hwrite) begin
      hrdata <= rd_new;
    end
  end
endmodule // cpu_register_file_flags
`default_nettype wire

// >>> src/regfile_consts.vh
// constants for the core register file and flag logic
// What this block does
// RULE_01 - main set: accumulator, flags, three pairs usable as 16-bit or two bytes
// RULE_02 - full alternate set, not addressable, swappable with the main set; shadow acc and flags still read at ADDR_SHADOW
// RULE_03 - special registers: vector base, refresh, two index, stack top, fetch pointer
// RULE_04 - vector base supplies high byte of vectored interrupt table address
// RULE_05 - vector base cleared to zero on reset
// RULE_06 - low seven refresh bits increment once per opcode fetch cycle
// RULE_07 - refresh counter cleared to zero on reset
// RULE_08 - indexed address is index register plus or minus displacement
// RULE_09 - stack top holds stack address, cleared to zero on reset
// RULE_10 - fetch pointer advances after each fetch, cleared on reset
// RULE_11 - sign flag bit 7 takes result msb
// RULE_12 - zero flag bit 6 set on zero result, else cleared
// RULE_13 - half carry bit 4 records carry or borrow out of low nibble for byte ops, out of bit 11 for word ops
// RULE_14 - after logic ops, bit 2 is one for even parity
// RULE_15 - after arithmetic, bit 2 is one on signed overflow, byte or word
// RULE_16 - negative flag bit 1 set for subtract types, cleared for add types
// RULE_17 - carry bit 0 from msb carry or borrow, also from shifts and rotates
// RULE_18 - defined flags clear on reset; bits 5 and 3 store what is written
// RULE_19 - exchange completes in one cycle, swapping both sets intact; a same-cycle bus store wins, and a store to no register holds acc
`ifndef REGFILE_CONSTS_VH
`define REGFILE_CONSTS_VH
// ------------------------------------------------------------
// flag bit positions
// ------------------------------------------------------------
`define FLAG_SIGN    7
`define FLAG_ZERO    6
`define FLAG_HALF    4
`define FLAG_PV      2
`define FLAG_NEG     1
`define FLAG_CARRY   0
// ------------------------------------------------------------
// register bus map (byte addresses)
// ------------------------------------------------------------
`define ADDR_ACC      8'h00
`define ADDR_FLAGS    8'h04
`define ADDR_PAIR1    8'h08
`define ADDR_PAIR2    8'h0C
`define ADDR_PAIR3    8'h10
`define ADDR_INDEX1   8'h14
`define ADDR_INDEX2   8'h18
`define ADDR_STACK    8'h1C
`define ADDR_FETCH    8'h20
`define ADDR_VECBASE  8'h24
`define ADDR_REFRESH  8'h28
`define ADDR_CONTROL  8'h2C
`define ADDR_SHADOW   8'h30
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
// ------------------------------------------------------------
// flag update op kinds
// ------------------------------------------------------------
`define FOP_NONE      3'h0
`define FOP_ADD8      3'h1
`define FOP_SUB8      3'h2
`define FOP_LOGIC     3'h3
`define FOP_SHIFT     3'h4
`define FOP_ADD16     3'h5
`define FOP_SUB16     3'h6
`endif

// >>> sim/core_model.sv
// stand-in for the decoder, alu and sequencer driving the core side
`timescale 1ns/1ns
`default_nettype none
`include "regfile_consts.vh"
module core_model (
  input  wire logic        clk_sys,
  output logic             fetch,
  output logic             swap,
  output logic [2:0]       op,
  output logic [15:0]      a,
  output logic [15:0]      b,
  output logic             cin
);
  initial begin
    fetch = 1'b0;
    swap = 1'b0;
    op = `FOP_NONE;
    a = 16'h0000;
    b = 16'h0000;
    cin = 1'b0;
  end
  // one request per call, held for a single edge, then back to idle
  task automatic pulse(input logic f, input logic s, input logic [2:0] o,
                       input logic [15:0] x, input logic [15:0] y, input logic c);
    @(posedge clk_sys);
    fetch <= f;
    swap <= s;
    op <= o;
    a <= x;
    b <= y;
    cin <= c;
    @(posedge clk_sys);
    fetch <= 1'b0;
    swap <= 1'b0;
    op <= `FOP_NONE;
  endtask
endmodule // core_model
`default_nettype wire

// >>> sim/cpu_register_file_flags_props.sv
// concurrent checks on the register file ports
`timescale 1ns/1ns
`default_nettype none
`include "regfile_consts.vh"
module cpu_register_file_flags_props (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic [2:0]  flag_op,
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic [7:0]  vector_low,
  input wire logic        exchange_sets,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] vector_address,
  input wire logic [15:0] index_address,
  input wire logic [15:0] result
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_bus_ready: assert property (hreadyout == 1'b1)
    else $error("hreadyout dropped");
  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_reset_clear: assert property ($fell(reset) |->
    vector_address == 16'h0000 && index_address == 16'h0000 && result == 16'h0000)
    else $error("outputs not cleared by reset");
  chk_vector_low: assert property (clk_en |=>
    vector_address[7:0] == $past(vector_low))
    else $error("vector low byte wrong");
  chk_add_byte: assert property (clk_en && flag_op == `FOP_ADD8 |=>
    result[7:0] == $past(op_a[7:0]) + $past(op_b[7:0]))
    else $error("byte sum wrong");
  chk_add_word: assert property (clk_en && flag_op == `FOP_ADD16 |=>
    result == $past(op_a) + $past(op_b))
    else $error("word sum wrong");
  chk_sub_word: assert property (clk_en && flag_op == `FOP_SUB16 |=>
    result == $past(op_a) - $past(op_b))
    else $error("word difference wrong");
  chk_frozen_state: assert property (!clk_en |=>
    $stable(result) && $stable(index_address) && $stable(vector_address))
    else $error("state moved while frozen");
  cover property (clk_en && flag_op == `FOP_SUB8);
  cover property (clk_en && exchange_sets);
  cover property (!clk_en ##1 clk_en);
endmodule // cpu_register_file_flags_props
bind cpu_register_file_flags cpu_register_file_flags_props u_props (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .flag_op(flag_op), .op_a(op_a),
  .op_b(op_b), .vector_low(vector_low), .exchange_sets(exchange_sets),
  .hreadyout(hreadyout), .hresp(hresp), .vector_address(vector_address),
  .index_address(index_address), .result(result));
`default_nettype wire

// >>> sim/cpu_register_file_flags_test.sv
// self-checking bench for the core register file
`timescale 1ns/1ns
`default_nettype none
`include "regfile_consts.vh"
module cpu_register_file_flags_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  disp = 8'h00;
  logic [7:0]  vlow = 8'h00;
  logic        dsub = 1'b0;
  logic        isel = 1'b0;
  logic [31:0] rd;
  wire         hreadyout, hresp, fetch, swap, cin;
  wire  [31:0] hrdata;
  wire  [15:0] index_address, vector_address, result, a, b;
  wire  [2:0]  op;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [7:0]  zaddr [6] = '{`ADDR_FLAGS, `ADDR_STACK, `ADDR_FETCH, `ADDR_VECBASE,
                             `ADDR_REFRESH, `ADDR_SHADOW};
  always #5 clk_sys = ~clk_sys;
  core_model u_core (.clk_sys(clk_sys), .fetch(fetch), .swap(swap), .op(op), .a(a),
                     .b(b), .cin(cin));
  cpu_register_file_flags DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .opcode_fetch_cycle(fetch), .exchange_sets(swap), .flag_op(op),
    .op_a(a), .op_b(b), .shift_carry(cin), .index_sel(isel), .displacement(disp),
    .disp_subtract(dsub), .index_address(index_address),
    .vector_address(vector_address), .vector_low(vlow), .result(result));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, adr};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check($sformatf("reg %h", adr), rd, exp);
  endtask
  task automatic end_sim;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rchk(zaddr[i], 32'h0);
    bus(1'b1, `ADDR_PAIR1, 32'h1234);
    rchk(`ADDR_PAIR1, 32'h1234);
    bus(1'b1, `ADDR_ACC, 32'h5A);
    bus(1'b1, `ADDR_FLAGS, 32'hFF);
    u_core.pulse(1'b0, 1'b1, `FOP_NONE, 16'h0, 16'h0, 1'b0);
    rchk(`ADDR_ACC, 32'h0);
    rchk(`ADDR_PAIR1, 32'h0);
    rchk(`ADDR_SHADOW, 32'h5AFF);
    u_core.pulse(1'b0, 1'b1, `FOP_NONE, 16'h0, 16'h0, 1'b0);
    rchk(`ADDR_PAIR1, 32'h1234);
    rchk(`ADDR_FLAGS, 32'hFF);
    bus(1'b1, `ADDR_FLAGS, 32'h0);
    u_core.pulse(1'b0, 1'b0, `FOP_ADD8, 16'h7F, 16'h01, 1'b0);
    @(negedge clk_sys);
    check("sum", {24'h0, result[7:0]}, 32'h80);
    rchk(`ADDR_FLAGS, 32'h94);
    u_core.pulse(1'b0, 1'b0, `FOP_SUB8, 16'h00, 16'h01, 1'b0);
    rchk(`ADDR_FLAGS, 32'h93);
    u_core.pulse(1'b0, 1'b0, `FOP_LOGIC, 16'h0, 16'h0, 1'b0);
    rchk(`ADDR_FLAGS, 32'h54);
    check("logic flags", rd & 32'hEF, 32'h44);
    u_core.pulse(1'b0, 1'b0, `FOP_SHIFT, 16'h0, 16'h0, 1'b1);
    rchk(`ADDR_FLAGS, 32'h45);
    check("shift carry", rd & 32'h1, 32'h1);
    u_core.pulse(1'b0, 1'b0, `FOP_ADD16, 16'h7FFF, 16'h0001, 1'b0);
    rchk(`ADDR_FLAGS, 32'h94);
    check("word overflow", rd & 32'h6, 32'h4);
    bus(1'b1, `ADDR_REFRESH, 32'hFF);
    repeat (3) u_core.pulse(1'b1, 1'b0, `FOP_NONE, 16'h0, 16'h0, 1'b0);
    rchk(`ADDR_REFRESH, 32'h82);
    rchk(`ADDR_FETCH, 32'h3);
    clk_en <= 1'b0;
    u_core.pulse(1'b1, 1'b0, `FOP_NONE, 16'h0, 16'h0, 1'b0);
    clk_en <= 1'b1;
    rchk(`ADDR_FETCH, 32'h3);
    bus(1'b1, `ADDR_INDEX1, 32'h1000);
    bus(1'b1, `ADDR_INDEX2, 32'h2000);
    bus(1'b1, `ADDR_VECBASE, 32'hAB);
    disp <= 8'h05;
    dsub <= 1'b1;
    vlow <= 8'h10;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("index minus", {16'h0, index_address}, 32'h0FFB);
    check("vector", {16'h0, vector_address}, 32'hAB10);
    @(posedge clk_sys);
    isel <= 1'b1;
    dsub <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("index plus", {16'h0, index_address}, 32'h2005);
    rchk(`ADDR_CONTROL, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFF);
    rchk(8'h40, 32'h0);
    bus(1'b1, `ADDR_STACK, 32'hBEEF);
    rchk(`ADDR_STACK, 32'hBEEF);
    // second reset in mid-run must clear values written above
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rchk(zaddr[i], 32'h0);
    end_sim();
  end
endmodule // cpu_register_file_flags_test
`default_nettype wire
